// *** hdl/rtf_tx_frame.sv ***
// Transmit framing, guard timer and edge shaping with an AHB-Lite register slave.
//
// Contract
// RULE1: Emit rise pattern after every rising edge.
// RULE2: Pattern length is field plus one, MSB-first.
// RULE3: Bit 0 enables rise-edge protection.
// RULE4: Miller pulse lasts width plus one clocks.
// RULE5: Phase field is first prescaler load.
// RULE6: Prescaler decrements every carrier clock.
// RULE7: Prescaler wrap decrements guard and reloads.
// RULE8: Card role: first load phase, later reload.
// RULE9: Phase, guard, prescaler set pre-transmit wait.
// RULE10: Guard value zero disables guard time.
// RULE11: Protocol detector overwrites guard and prescaler.
// RULE12: Software programs prescaler reload to 0x7F.
// RULE13: Invert parity of final byte when set.
// RULE14: Parity type zero even, one odd.
// RULE15: Parity appended after each byte when enabled.
// RULE16: Zero byte count with data raises error.
// RULE17: Data disabled sends only start/stop symbols.
// RULE18: Stop field selects none or symbol 1-3.
// RULE19: Start field selects none or symbol 0-2.
// RULE20: Last-bits field trims end of final byte.
// RULE21: First-bits field trims start of first byte.
// RULE22: Order: guard, start, data+parity, stop.
// RULE23: Pattern bits applied one per clock.
`timescale 1ns/10ps
`default_nettype none

module rtf_tx_frame
  import rtf_pkg::*;
#(
  parameter int DEPTH = 16
) (
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic [31:0]      hrdata_out,
  output logic             hreadyout_out,
  output logic             hresp_out,
  input  wire logic        det_load_in,
  input  wire logic [19:0] det_guard_in,
  input  wire logic [7:0]  det_prescale_in,
  input  wire logic        mod_env_in,
  output rtf_tx_t          tx_out,
  output logic             shape_out,
  output logic             shape_valid_out,
  output logic             miller_pulse_out,
  output logic             busy_out,
  output logic             no_data_err_out
);

  localparam int AW = $clog2(DEPTH);

  logic [31:0]      rise_reg;
  logic [15:0]      pulse_reg;
  logic [19:0]      guard_val_reg;
  logic [7:0]       prescale_reg;
  logic [13:0]      format_reg;
  logic             card_role_reg;
  logic [8:0]       nbytes_reg;
  logic [7:0]       mem [DEPTH];
  logic [AW-1:0]    wptr_reg;
  logic             start_reg;
  logic             err_reg;

  logic             ap_valid_reg;
  logic             ap_write_reg;
  logic [7:0]       ap_idx_reg;

  rtf_state_t       state_reg;
  logic [19:0]      gcnt_reg;
  logic [7:0]       pcnt_reg;
  logic [8:0]       byte_idx_reg;
  logic [2:0]       bit_idx_reg;
  logic             par_reg;
  rtf_tx_t          tx_reg;

  logic             env_s1_reg;
  logic             env_s2_reg;
  logic             env_d_reg;
  logic [4:0]       shape_cnt_reg;
  logic [7:0]       pulse_cnt_reg;

  rtf_rise_t        rise;
  rtf_format_t      fmt;
  logic [7:0]       cur_byte;
  logic             is_first;
  logic             is_last;
  logic [2:0]       bit_lo;
  logic [2:0]       bit_hi;
  logic             ap_take;

  assign rise     = {rise_reg[31:16], rise_reg[4:0]};
  assign fmt      = format_reg;
  assign cur_byte = mem[byte_idx_reg[AW-1:0]];
  assign is_first = (byte_idx_reg == 9'h000);
  assign is_last  = (byte_idx_reg == nbytes_reg - 9'h001);
  assign ap_take  = hsel_in && htrans_in[1] && hready_in;

  // Bits go LSB first; trimming the first byte skips low bits, the last byte drops high bits.
  always_comb begin
    // RULE21 first-byte trim
    bit_lo = (is_first && fmt.first_bits != 3'h0) ? 3'(8 - fmt.first_bits) : 3'h0;
    // RULE20 last-byte trim
    bit_hi = (is_last && fmt.last_bits != 3'h0) ? 3'(fmt.last_bits - 3'h1) : 3'h7;
  end

  // Bus address phase capture; the slave always answers with zero wait states.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ap_valid_reg <= 1'b0;
      ap_write_reg <= 1'b0;
      ap_idx_reg   <= 8'h00;
    end else if (hready_in) begin
      ap_valid_reg <= ap_take;
      ap_write_reg <= hwrite_in;
      ap_idx_reg   <= haddr_in[9:2];
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      hreadyout_out <= 1'b1;
      hresp_out     <= 1'b0;
    end else begin
      hreadyout_out <= 1'b1;
      hresp_out     <= 1'b0;
    end
  end

  // Read data is registered from the address phase so it is ready in the data phase.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      hrdata_out <= 32'h0000_0000;
    end else if (ap_take && !hwrite_in) begin
      unique case (haddr_in[9:2])
        RTF_IDX_RISE:   hrdata_out <= rise_reg;
        RTF_IDX_PULSE:  hrdata_out <= {16'h0000, pulse_reg};
        RTF_IDX_GUARD:  hrdata_out <= {4'h0, guard_val_reg, prescale_reg};
        RTF_IDX_FORMAT: hrdata_out <= {18'h00000, format_reg};
        RTF_IDX_CTRL:   hrdata_out <= {15'h0000, nbytes_reg, 6'h00, card_role_reg, start_reg};
        RTF_IDX_STATUS: hrdata_out <= {28'h0000000, 3'(state_reg), err_reg};
        default:        hrdata_out <= 32'h0000_0000;
      endcase
    end
  end

  logic wr;
  assign wr = ap_valid_reg && ap_write_reg;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rise_reg   <= RTF_RISE_RESET;
      pulse_reg  <= RTF_PULSE_RESET[15:0];
      format_reg <= RTF_FORMAT_RESET[13:0];
    end else if (wr) begin
      if (ap_idx_reg == RTF_IDX_RISE) rise_reg <= hwdata_in & RTF_RISE_MASK;
      if (ap_idx_reg == RTF_IDX_PULSE) pulse_reg <= hwdata_in[15:0];
      if (ap_idx_reg == RTF_IDX_FORMAT) format_reg <= hwdata_in[13:0];
    end
  end

  // Guard setup: the detector load takes priority over a same-cycle software write.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      guard_val_reg <= RTF_GUARD_RESET[27:8];
      prescale_reg  <= RTF_GUARD_RESET[7:0];
    end else if (det_load_in) begin
      // RULE11 detector overwrite
      guard_val_reg <= det_guard_in;
      prescale_reg  <= det_prescale_in;
    end else if (wr && ap_idx_reg == RTF_IDX_GUARD) begin
      guard_val_reg <= hwdata_in[27:8];
      prescale_reg  <= hwdata_in[7:0];
    end
  end

  // Control, transmit data and error flag; a raised error beats a clear.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      card_role_reg <= 1'b0;
      nbytes_reg    <= 9'h000;
      wptr_reg      <= '0;
      start_reg     <= 1'b0;
      err_reg       <= 1'b0;
    end else begin
      // The start strobe lives one cycle so a refused start cannot re-raise the error.
      start_reg <= 1'b0;
      if (wr && ap_idx_reg == RTF_IDX_CTRL) begin
        card_role_reg <= hwdata_in[RTF_C_CARD_ROLE];
        nbytes_reg    <= hwdata_in[16:8];
        start_reg     <= hwdata_in[RTF_C_START] && state_reg == RTF_IDLE;
        wptr_reg      <= '0;
      end else if (wr && ap_idx_reg == RTF_IDX_TXDATA) begin
        wptr_reg <= AW'(wptr_reg + 1'b1);
      end
      if (wr && ap_idx_reg == RTF_IDX_STATUS && hwdata_in[0]) err_reg <= 1'b0;
      // RULE16 no-data error
      if (state_reg == RTF_IDLE && start_reg && fmt.data_en && nbytes_reg == 9'h000) begin
        err_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (wr && ap_idx_reg == RTF_IDX_TXDATA) mem[wptr_reg] <= hwdata_in[7:0];
  end

  // Frame sequencer with the two-counter guard timer.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg    <= RTF_IDLE;
      gcnt_reg     <= 20'h0_0000;
      pcnt_reg     <= 8'h00;
      byte_idx_reg <= 9'h000;
      bit_idx_reg  <= 3'h0;
      par_reg      <= 1'b0;
      tx_reg       <= '0;
    end else begin
      tx_reg.valid <= 1'b0;
      unique case (state_reg)
        RTF_IDLE: begin
          if (start_reg && !(fmt.data_en && nbytes_reg == 9'h000)) begin
            gcnt_reg <= guard_val_reg;
            // RULE5 phase as first load
            // RULE8 card role selects phase
            pcnt_reg <= card_role_reg ? first_prescale_phase() : prescale_reg;
            byte_idx_reg <= 9'h000;
            // RULE10 zero guard skips wait
            // RULE22 guard before start
            state_reg <= (guard_val_reg == RTF_GUARD_OFF) ? RTF_START : RTF_GUARD;
          end
        end
        RTF_GUARD: begin
          // RULE6 decrement every clock
          // RULE9 wait built from all three
          pcnt_reg <= pcnt_reg - 8'h01;
          if (pcnt_reg == 8'h00) begin
            // RULE7 wrap reload and decrement
            pcnt_reg <= prescale_reg;
            gcnt_reg <= gcnt_reg - 20'h0_0001;
            if (gcnt_reg == 20'h0_0001) state_reg <= RTF_START;
          end
        end
        RTF_START: begin
          // RULE19 start symbol map
          if (fmt.start_sym != 2'b00) begin
            tx_reg <= '{valid: 1'b1, is_symbol: 1'b1, symbol: 2'(fmt.start_sym - 2'b01),
                        bit_val: 1'b0};
          end
          // RULE17 data enable gate
          state_reg   <= fmt.data_en ? RTF_DATA : RTF_STOP;
          bit_idx_reg <= bit_lo;
          par_reg     <= 1'b0;
        end
        RTF_DATA: begin
          tx_reg  <= '{valid: 1'b1, is_symbol: 1'b0, symbol: 2'b00,
                       bit_val: cur_byte[bit_idx_reg]};
          par_reg <= par_reg ^ cur_byte[bit_idx_reg];
          if (bit_idx_reg == bit_hi) begin
            // RULE15 parity after byte
            if (fmt.par_en) begin
              state_reg <= RTF_PARITY;
            end else if (is_last) begin
              state_reg <= RTF_STOP;
            end else begin
              byte_idx_reg <= byte_idx_reg + 9'h001;
              bit_idx_reg  <= 3'h0;
              par_reg      <= 1'b0;
            end
          end else begin
            bit_idx_reg <= bit_idx_reg + 3'h1;
          end
        end
        RTF_PARITY: begin
          // RULE14 even or odd
          // RULE13 invert final parity
          tx_reg <= '{valid: 1'b1, is_symbol: 1'b0, symbol: 2'b00,
                      bit_val: par_reg ^ fmt.par_odd ^ (fmt.inv_last && is_last)};
          if (is_last) begin
            state_reg <= RTF_STOP;
          end else begin
            byte_idx_reg <= byte_idx_reg + 9'h001;
            bit_idx_reg  <= 3'h0;
            par_reg      <= 1'b0;
            state_reg    <= RTF_DATA;
          end
        end
        RTF_STOP: begin
          // RULE18 stop symbol map
          if (fmt.stop_sym != 2'b00) begin
            tx_reg <= '{valid: 1'b1, is_symbol: 1'b1, symbol: fmt.stop_sym, bit_val: 1'b0};
          end
          state_reg <= RTF_IDLE;
        end
      endcase
    end
  end

  function automatic logic [7:0] first_prescale_phase();
    return pulse_reg[7:0];
  endfunction

  // The modulation envelope comes from the analog side and is synchronised first.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      env_s1_reg <= 1'b0;
      env_s2_reg <= 1'b0;
      env_d_reg  <= 1'b0;
    end else begin
      env_s1_reg <= mod_env_in;
      env_s2_reg <= env_s1_reg;
      env_d_reg  <= env_s2_reg;
    end
  end

  // Shaping pattern walks from bit 15 downward, one bit per clock after a rising edge.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      shape_cnt_reg   <= 5'h00;
      shape_out       <= 1'b0;
      shape_valid_out <= 1'b0;
    end else begin
      shape_valid_out <= 1'b0;
      shape_out       <= 1'b0;
      // RULE3 enable gate
      // RULE1 trigger on rising edge
      if (rise.protect_en && env_s2_reg && !env_d_reg) begin
        // RULE2 length plus one
        shape_cnt_reg <= 5'(rise.pattern_len) + 5'h01;
      end else if (shape_cnt_reg != 5'h00) begin
        // RULE23 one bit per clock
        shape_valid_out <= 1'b1;
        // Bit 15 goes out first, the last one sent is bit 15 minus the length field.
        shape_out       <= rise.pattern[4'(5'd14 + shape_cnt_reg - 5'(rise.pattern_len))];
        shape_cnt_reg   <= shape_cnt_reg - 5'h01;
      end
    end
  end

  // Miller pulse: each data bit at one starts a pulse of width plus one clocks.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pulse_cnt_reg    <= 8'h00;
      miller_pulse_out <= 1'b0;
    end else if (tx_reg.valid && !tx_reg.is_symbol && tx_reg.bit_val) begin
      // RULE4 pulse width plus one
      pulse_cnt_reg    <= pulse_reg[15:8];
      miller_pulse_out <= 1'b1;
    end else if (pulse_cnt_reg != 8'h00) begin
      pulse_cnt_reg <= pulse_cnt_reg - 8'h01;
    end else begin
      miller_pulse_out <= 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tx_out          <= '0;
      busy_out        <= 1'b0;
      no_data_err_out <= 1'b0;
    end else begin
      tx_out          <= tx_reg;
      busy_out        <= state_reg != RTF_IDLE;
      no_data_err_out <= err_reg;
    end
  end

endmodule // rtf_tx_frame

`default_nettype wire

// *** pkg/rtf_pkg.sv ***
// Package for the transmit framing block: register map, fields, reset values and types.
package rtf_pkg;

  // Register indices as printed; byte address is four times the index.
  localparam logic [7:0] RTF_IDX_RISE     = 8'h15;
  localparam logic [7:0] RTF_IDX_PULSE    = 8'h16;
  localparam logic [7:0] RTF_IDX_GUARD    = 8'h17;
  localparam logic [7:0] RTF_IDX_FORMAT   = 8'h18;
  localparam logic [7:0] RTF_IDX_CTRL     = 8'h1c;
  localparam logic [7:0] RTF_IDX_STATUS   = 8'h1d;
  localparam logic [7:0] RTF_IDX_TXDATA   = 8'h1e;

  localparam logic [31:0] RTF_RISE_RESET   = 32'h0000_0000;
  localparam logic [31:0] RTF_PULSE_RESET  = 32'h0000_0000;
  localparam logic [31:0] RTF_GUARD_RESET  = 32'h0000_0000;
  localparam logic [31:0] RTF_FORMAT_RESET = 32'h0000_0000;
  // Writable-bit masks; everything else is reserved and reads zero.
  localparam logic [31:0] RTF_RISE_MASK    = 32'hffff_001f;
  localparam logic [31:0] RTF_PULSE_MASK   = 32'h0000_ffff;
  localparam logic [31:0] RTF_GUARD_MASK   = 32'h0fff_ffff;
  localparam logic [31:0] RTF_FORMAT_MASK  = 32'h0000_3fff;

  // Format register field positions.
  localparam int RTF_F_INV_LAST  = 13;
  localparam int RTF_F_PAR_ODD   = 12;
  localparam int RTF_F_PAR_EN    = 11;
  localparam int RTF_F_DATA_EN   = 10;
  // Control register: bit 0 starts a frame, bits 16:8 hold the byte count.
  localparam int RTF_C_START     = 0;
  localparam int RTF_C_CARD_ROLE = 1;

  localparam logic [7:0]  RTF_PRESCALE_WRAP = 8'hff;
  localparam logic [19:0] RTF_GUARD_OFF     = 20'h0_0000;

  typedef struct packed {
    logic [15:0] pattern;
    logic [3:0]  pattern_len;
    logic        protect_en;
  } rtf_rise_t;

  typedef struct packed {
    logic       inv_last;
    logic       par_odd;
    logic       par_en;
    logic       data_en;
    logic [1:0] stop_sym;
    logic [1:0] start_sym;
    logic [2:0] last_bits;
    logic [2:0] first_bits;
  } rtf_format_t;

  // Symbol-channel output toward the modulator.
  typedef struct packed {
    logic       valid;
    logic       is_symbol;
    logic [1:0] symbol;
    logic       bit_val;
  } rtf_tx_t;

  typedef enum logic [2:0] {
    RTF_IDLE, RTF_GUARD, RTF_START, RTF_DATA, RTF_PARITY, RTF_STOP
  } rtf_state_t;

endpackage : rtf_pkg

// *** tb/rtf_mod_model.sv ***
// Behavioural modulator: logs symbols and bits, keys the envelope, logs shaping.
`timescale 1ns/10ps
`default_nettype none

module rtf_mod_model
  import rtf_pkg::*;
(
  input  wire logic    clk_in,
  input  wire logic    rst_n_in,
  input  wire rtf_tx_t tx_in,
  input  wire logic    shape_in,
  input  wire logic    shape_valid_in,
  input  wire logic    miller_in,
  output logic         env_out
);
  logic [3:0] seen[$];
  logic       shape_q[$];
  int         n_hi;

  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      env_out <= 1'b0;
    end else begin
      // Only data and parity ones key the carrier, so runs of ones give a single rising edge.
      env_out <= tx_in.valid & tx_in.bit_val & ~tx_in.is_symbol;
      if (tx_in.valid) begin
        seen.push_back(tx_in.is_symbol ? {1'b1, tx_in.symbol, 1'b0} : {3'b000, tx_in.bit_val});
      end
      if (shape_valid_in) begin
        shape_q.push_back(shape_in);
      end
      if (miller_in) begin
        n_hi++;
      end
    end
  end
endmodule // rtf_mod_model

`default_nettype wire

// *** tb/rtf_tx_frame_properties.sv ***
// Port-level assertions for the transmit framing block.
`timescale 1ns/10ps
`default_nettype none

module rtf_tx_frame_properties
  import rtf_pkg::*;
(
  input wire logic        clk_in,
  input wire logic        rst_n_in,
  input wire logic        hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0]  htrans_in,
  input wire logic        hwrite_in,
  input wire logic        hready_in,
  input wire logic [31:0] hrdata_out,
  input wire logic        hreadyout_out,
  input wire logic        hresp_out,
  input wire rtf_tx_t     tx_out,
  input wire logic        miller_pulse_out,
  input wire logic        busy_out,
  input wire logic        no_data_err_out
);
  logic       rd_pend_reg;
  logic [7:0] rd_idx_reg;
  logic       mapped;
  logic       one_bit;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);

  assign one_bit = tx_out.valid & tx_out.bit_val & ~tx_out.is_symbol;
  assign mapped  = rd_idx_reg inside {RTF_IDX_RISE, RTF_IDX_PULSE, RTF_IDX_GUARD,
                   RTF_IDX_FORMAT, RTF_IDX_CTRL, RTF_IDX_STATUS, RTF_IDX_TXDATA};

  // Remember the read address so the data phase can be judged.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rd_pend_reg <= 1'b0;
      rd_idx_reg  <= 8'h00;
    end else if (hready_in) begin
      rd_pend_reg <= hsel_in & htrans_in[1] & ~hwrite_in;
      rd_idx_reg  <= haddr_in[9:2];
    end
  end

  property p_bus_okay;
    hreadyout_out && !hresp_out;
  endproperty
  a_bus_okay: assert property (p_bus_okay) else $error("bus stalled or not okay");

  property p_unmapped;
    rd_pend_reg && !mapped |-> hrdata_out == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

  property p_fmt_rsv;
    rd_pend_reg && rd_idx_reg == RTF_IDX_FORMAT |-> hrdata_out[31:14] == 18'h0;
  endproperty
  a_fmt_rsv: assert property (p_fmt_rsv) else $error("format reserved bits set");

  property p_rise_rsv;
    rd_pend_reg && rd_idx_reg == RTF_IDX_RISE |-> hrdata_out[15:5] == 11'h0;
  endproperty
  a_rise_rsv: assert property (p_rise_rsv) else $error("shaping reserved bits set");

  property p_err_hold;
    no_data_err_out && !hsel_in && !$past(hsel_in) && !$past(hsel_in, 2) |=> no_data_err_out;
  endproperty
  a_err_hold: assert property (p_err_hold) else $error("error flag dropped");

  property p_err_quiet;
    $rose(no_data_err_out) |-> !tx_out.valid [*4];
  endproperty
  a_err_quiet: assert property (p_err_quiet) else $error("frame sent on error");

  property p_miller_src;
    $rose(miller_pulse_out) |-> one_bit || $past(one_bit) || $past(one_bit, 2);
  endproperty
  a_miller_src: assert property (p_miller_src) else $error("pulse without one bit");

  property p_tx_busy;
    tx_out.valid |-> busy_out || $past(busy_out);
  endproperty
  a_tx_busy: assert property (p_tx_busy) else $error("output while idle");
endmodule // rtf_tx_frame_properties

`default_nettype wire

// *** tb/testbench.sv ***
// Register-driven frame tests against the modulator model.
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
  $display("FAIL %s exp %h got %h", n, e, g); end end

module testbench;
  import rtf_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic        det_load = 1'b0;
  logic [31:0] hrdata;
  logic        hready;
  logic        hresp;
  logic        env;
  logic        shape;
  logic        shape_v;
  logic        miller;
  logic        busy;
  logic        err;
  rtf_tx_t     tx;
  logic [3:0]  exp_q[$];
  logic [31:0] rd;
  int          n_fail = 0;
  int          n_tests = 0;
  int          t0;
  int          base;

  always #4 clk = ~clk;

  rtf_tx_frame DUT (.clk_in(clk), .rst_n_in(rst_n), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
    .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
    .det_load_in(det_load), .det_guard_in(20'h00003), .det_prescale_in(8'h05),
    .mod_env_in(env), .tx_out(tx), .shape_out(shape), .shape_valid_out(shape_v),
    .miller_pulse_out(miller), .busy_out(busy), .no_data_err_out(err));

  rtf_mod_model mdl (.clk_in(clk), .rst_n_in(rst_n), .tx_in(tx), .shape_in(shape),
    .shape_valid_in(shape_v), .miller_in(miller), .env_out(env));

  task automatic give_verdict;
    $display("tests %0d fails %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic wait_rdy;
    int k;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (hready !== 1'b1 && k < 64);
    if (k >= 64) begin
      n_fail++;
      give_verdict();
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] wd);
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {22'h0, idx, 2'h0};
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask

  // The first control write rewinds the byte pointer before the bytes go in.
  task automatic frame(input int n, input logic [15:0] b, input logic role);
    int k;
    bus(1'b1, RTF_IDX_CTRL, 32'(n) << 8);
    for (k = 0; k < n; k++) bus(1'b1, RTF_IDX_TXDATA, {24'h0, b[8*k +: 8]});
    mdl.seen.delete();
    mdl.shape_q.delete();
    mdl.n_hi = 0;
    bus(1'b1, RTF_IDX_CTRL, (32'(n) << 8) | {30'h0, role, 1'b1});
    k = 0;
    // A frame with nothing to send is over once busy is low after more than 8 cycles.
    while (tx.valid !== 1'b1 && !(k > 8 && busy === 1'b0) && k < 400) begin
      @(posedge clk);
      k++;
    end
    t0 = k;
    while (busy !== 1'b0 && k < 800) begin
      @(posedge clk);
      k++;
    end
    if (k >= 400) begin
      n_fail++;
      give_verdict();
    end
    repeat (3) @(posedge clk);
  endtask

  task automatic push_bits(input logic [7:0] v, input int lo, input int hi);
    int k;
    for (k = lo; k <= hi; k++) exp_q.push_back({3'b000, v[k]});
  endtask

  task automatic cmp_q(input string nm);
    int i;
    `CHK(nm, exp_q.size(), mdl.seen.size())
    for (i = 0; i < exp_q.size() && i < mdl.seen.size(); i++) `CHK(nm, exp_q[i], mdl.seen[i])
  endtask

  logic [7:0]  idx_t[5] = '{RTF_IDX_RISE, RTF_IDX_PULSE, RTF_IDX_GUARD, RTF_IDX_FORMAT, 8'h10};
  logic [31:0] msk_t[5] = '{RTF_RISE_MASK, RTF_PULSE_MASK, RTF_GUARD_MASK, RTF_FORMAT_MASK, 32'h0};

  initial begin
    int i;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    for (i = 0; i < 5; i++) begin
      bus(1'b0, idx_t[i], 32'h0);
      `CHK("reset", 32'h0, rd)
      bus(1'b1, idx_t[i], 32'hffff_ffff);
      bus(1'b0, idx_t[i], 32'h0);
      `CHK("mask", msk_t[i], rd)
      bus(1'b1, idx_t[i], 32'h0);
    end
    $display("done: registers");
    @(posedge clk);
    det_load <= 1'b1;
    @(posedge clk);
    det_load <= 1'b0;
    bus(1'b0, RTF_IDX_GUARD, 32'h0);
    `CHK("detector", 32'h0000_0305, rd)
    bus(1'b1, RTF_IDX_GUARD, 32'h0);
    $display("done: detector");
    for (i = 0; i < 4; i++) begin
      bus(1'b1, RTF_IDX_FORMAT, 32'(i) * 32'h0000_0140);
      frame(0, 16'h0, 1'b0);
      if (i == 1) base = t0;
      exp_q.delete();
      if (i > 0) exp_q.push_back({1'b1, 2'(i - 1), 1'b0});
      if (i > 0) exp_q.push_back({1'b1, 2'(i), 1'b0});
      cmp_q("symbols");
      `CHK("no error", 1'b0, err)
    end
    $display("done: symbols");
    // Guard 2 with reload 0x7f and phase 1 adds 2 + 128 carrier clocks.
    bus(1'b1, RTF_IDX_GUARD, 32'h0000_027f);
    bus(1'b1, RTF_IDX_PULSE, 32'h0000_0201);
    bus(1'b1, RTF_IDX_FORMAT, 32'h0000_0040);
    frame(0, 16'h0, 1'b1);
    `CHK("guard", base + 130, t0)
    bus(1'b1, RTF_IDX_GUARD, 32'h0);
    $display("done: guard");
    bus(1'b1, RTF_IDX_RISE, 32'hb000_0007);
    bus(1'b1, RTF_IDX_FORMAT, 32'h0000_0400);
    frame(1, 16'h0001, 1'b0);
    `CHK("shape count", 4, mdl.shape_q.size())
    for (i = 0; i < 4 && i < mdl.shape_q.size(); i++) begin
      `CHK("shape", 4'hb >> (3 - i) & 1'b1, mdl.shape_q[i])
    end
    `CHK("pulse", 3, mdl.n_hi)
    $display("done: shaping");
    bus(1'b1, RTF_IDX_RISE, 32'h0);
    bus(1'b1, RTF_IDX_FORMAT, 32'h0000_3c00);
    frame(2, 16'h0103, 1'b0);
    exp_q.delete();
    push_bits(8'h03, 0, 7);
    exp_q.push_back(4'h1);
    push_bits(8'h01, 0, 7);
    exp_q.push_back(4'h1);
    cmp_q("parity");
    `CHK("shape off", 0, mdl.shape_q.size())
    $display("done: parity");
    bus(1'b1, RTF_IDX_FORMAT, 32'h0000_0413);
    frame(2, 16'h0dff, 1'b0);
    exp_q.delete();
    push_bits(8'hff, 5, 7);
    push_bits(8'h0d, 0, 1);
    cmp_q("partial");
    $display("done: partial");
    frame(0, 16'h0, 1'b0);
    exp_q.delete();
    cmp_q("no frame");
    `CHK("error", 1'b1, err)
    bus(1'b0, RTF_IDX_STATUS, 32'h0);
    `CHK("status", 1'b1, rd[0])
    bus(1'b1, RTF_IDX_STATUS, 32'h1);
    repeat (2) @(posedge clk);
    `CHK("cleared", 1'b0, err)
    $display("done: error");
    give_verdict();
  end
endmodule // testbench

bind rtf_tx_frame rtf_tx_frame_properties u_chk (.clk_in(clk_in), .rst_n_in(rst_n_in),
  .hsel_in(hsel_in), .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in),
  .hready_in(hready_in), .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out),
  .hresp_out(hresp_out), .tx_out(tx_out), .miller_pulse_out(miller_pulse_out),
  .busy_out(busy_out), .no_data_err_out(no_data_err_out));

`default_nettype wire
